/* hw/mode_regs_defines.vh */
// Offsets, field positions, reset values and timing for the mode and test register bank.
`ifndef MODE_REGS_DEFINES_VH
`define MODE_REGS_DEFINES_VH
`define OFS_CLEAR_WINDOW 16'h102e
`define OFS_MODE_SET 16'h1032
`define OFS_MODE_CLEAR 16'h1034
`define OFS_TEST_WR_ADDR 16'h1036
`define OFS_TEST_PAT_UPPER 16'h1038
`define OFS_TEST_PAT_LOWER 16'h103a
`define OFS_CRATE_NUMBER 16'h103c
`define OFS_TEST_EVENT_LOAD 16'h103e
`define OFS_EVENT_COUNT_CLEAR 16'h1040
`define OFS_PEDESTAL 16'h1060
`define OFS_TEST_RD_ADDR 16'h1064
`define OFS_SLIDE_CONST 16'h106a
`define OFS_INCR_EVENT 16'h1028
`define OFS_INCR_OFFSET 16'h102a
`define BIT_MEM_TEST 0
`define BIT_CONV_HALT 1
`define BIT_DATA_WIPE 2
`define BIT_OVF_CHECK_DIS 3
`define BIT_ZERO_SUP_DIS 4
`define BIT_ACQ_CHECK 6
`define BIT_DITHER_SCALE 7
`define BIT_THRESHOLD_STEP 8
`define BIT_PTR_AUTO_ADV 11
`define BIT_EMPTY_EVENT 12
`define BIT_SLIDE_SUB_DIS 13
`define BIT_COUNT_EVERY 14
`define MODE_RESET 16'h4880
`define MODE_MASK 16'h79df
`define CLEAR_WINDOW_MAX 10'h3f0
`define CLEAR_WINDOW_BASE_NS 7000
`define CLOCK_STEP_NS_X32 1000
`define TEST_FIFO_DEPTH 32
`endif

/* hw/mode_regs.v */
// Mode and test control register bank of a 32-channel charge converter module.
//
// Operation
// - Clear window is 7 us plus written count times 1/32 us; count capped at 0x3f0.
// - Mode set writes: ones set mode bits, zeros leave them; reads return mode bits.
// - Mode clear writes: ones clear matching mode bits, zeros have no effect.
// - Mode bit 0 selects random memory access test, allowing direct buffer writes.
// - Converter halt bit takes the converter controller offline, no conversions.
// - Data-wipe bit generates data reset of data, pointers, counter and integrators.
// - Overflow check disable at zero stores only non-overflowed values; one stores all.
// - Zero-suppress disable at zero stores values above threshold; one stores all.
// - Mode bit 6 takes event data from test FIFO instead of conversions.
// - Dither scale bit one runs sliding scale; zero drives slide constant.
// - Threshold step selects result bits 11..4 or bits 8..1 for compare.
// - Auto-advance moves read pointer on readout; else only on increment writes.
// - Empty-event bit one writes header and trailer word for empty events.
// - Sliding subtraction disable bypasses the subtraction section, test use only.
// - Count-every-trigger counts all triggers; otherwise only accepted triggers.
// - Memory test: address, upper half, lower half; lower write commits 32 bits.
// - Host programs crate number; device inserts it into stored data words.
// - Each test event write loads one word into a 32-word circular test FIFO.
// - Test word carries 12-bit value and overflow flag copied into stored event.
// - Any write to event counter clear location clears the event counter.
// - Slide constant holds 8 bits driving the sliding scale when disabled.
// - Increment event write moves read pointer to next event's first word, only while auto-advance is off.
`timescale 1ns/10ps
`include "mode_regs_defines.vh"
module mode_regs (
  input wire CLK,
  input wire RST,
  input wire WR,
  input wire RD,
  input wire [15:0] ADDR,
  input wire [15:0] WDATA,
  output reg [15:0] RDATA,
  output reg RVALID,
  input wire TEST_FIFO_POP,
  input wire [11:0] CONV_RESULT,
  input wire [7:0] THRESHOLD,
  output reg [15:0] CLEAR_WINDOW_CYCLES,
  output reg MEM_TEST_MODE,
  output reg CONV_OFFLINE,
  output reg DATA_RESET,
  output reg STORE_OVERFLOWED,
  output reg STORE_ALL_LEVELS,
  output reg ACQ_CHECK_MODE,
  output reg [7:0] SLIDE_DAC_CONST,
  output reg SLIDE_DAC_FIXED,
  output reg SLIDE_SUB_BYPASS,
  output reg ABOVE_THRESHOLD,
  output reg PTR_AUTO_ADVANCE,
  output reg ADVANCE_EVENT,
  output reg ADVANCE_WORD,
  output reg EMPTY_EVENT_RECORD,
  output reg COUNT_EVERY_TRIGGER,
  output reg EVENT_COUNT_CLEAR,
  output reg [15:0] MEM_TEST_WR_ADDR,
  output reg [15:0] MEM_TEST_RD_ADDR,
  output reg [31:0] MEM_TEST_WORD,
  output reg MEM_TEST_COMMIT,
  output reg [7:0] CRATE_NUMBER,
  output reg [7:0] PEDESTAL_CURRENT,
  output reg [11:0] TEST_VALUE,
  output reg TEST_OVERFLOW
);
  reg [15:0] mode_ff;
  reg [9:0] window_ff;
  reg [15:0] upper_ff;
  reg [15:0] fifo_mem [0:`TEST_FIFO_DEPTH-1];
  reg [4:0] wptr_ff;
  reg [4:0] rptr_ff;
  reg [15:0] nxt_mode;
  reg [15:0] nxt_rdata;
  reg nxt_rvalid;
  wire [15:0] mode_mask = `MODE_MASK;
  function hit;
    input [15:0] a;
    input [15:0] ofs;
    begin
      hit = WR && (a == ofs);
    end
  endfunction

  // Window count in 10 ns cycles: 700 plus N * 3.125 cycles, rounded up.
  function [15:0] window_cycles;
    input [9:0] n;
    reg [19:0] t;
    reg [19:0] q;
    begin
      t = (20'd0 + n) * 20'd1000 / 20'd32 + 20'd7000;
      q = t / 20'd10 + (((t % 20'd10) != 20'd0) ? 20'd1 : 20'd0);
      // The largest count gives 3850 cycles, so the upper bits are always zero.
      window_cycles = q[15:0];
    end
  endfunction

  always @* begin
    nxt_mode = mode_ff;
    if (hit(ADDR, `OFS_MODE_SET)) begin
      nxt_mode = mode_ff | (WDATA & mode_mask);
    end
    if (hit(ADDR, `OFS_MODE_CLEAR)) begin
      nxt_mode = mode_ff & ~(WDATA & mode_mask);
    end
  end

  always @* begin
    nxt_rvalid = RD;
    case (ADDR)
      `OFS_CLEAR_WINDOW: nxt_rdata = {6'h00, window_ff};
      `OFS_MODE_SET: nxt_rdata = mode_ff;
      `OFS_CRATE_NUMBER: nxt_rdata = {8'h00, CRATE_NUMBER};
      `OFS_PEDESTAL: nxt_rdata = {8'h00, PEDESTAL_CURRENT};
      `OFS_SLIDE_CONST: nxt_rdata = {8'h00, SLIDE_DAC_CONST};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_ff <= `MODE_RESET;
      window_ff <= 10'h000;
      upper_ff <= 16'h0000;
      wptr_ff <= 5'h00;
      rptr_ff <= 5'h00;
      RDATA <= 16'h0000;
      RVALID <= 1'b0;
      CLEAR_WINDOW_CYCLES <= 16'h02bc;
      MEM_TEST_MODE <= 1'b0;
      CONV_OFFLINE <= 1'b0;
      DATA_RESET <= 1'b0;
      STORE_OVERFLOWED <= 1'b0;
      STORE_ALL_LEVELS <= 1'b0;
      ACQ_CHECK_MODE <= 1'b0;
      SLIDE_DAC_CONST <= 8'h00;
      SLIDE_DAC_FIXED <= 1'b0;
      SLIDE_SUB_BYPASS <= 1'b0;
      ABOVE_THRESHOLD <= 1'b0;
      PTR_AUTO_ADVANCE <= 1'b1;
      ADVANCE_EVENT <= 1'b0;
      ADVANCE_WORD <= 1'b0;
      EMPTY_EVENT_RECORD <= 1'b0;
      COUNT_EVERY_TRIGGER <= 1'b1;
      EVENT_COUNT_CLEAR <= 1'b0;
      MEM_TEST_WR_ADDR <= 16'h0000;
      MEM_TEST_RD_ADDR <= 16'h0000;
      MEM_TEST_WORD <= 32'h00000000;
      MEM_TEST_COMMIT <= 1'b0;
      CRATE_NUMBER <= 8'h00;
      PEDESTAL_CURRENT <= 8'h00;
      TEST_VALUE <= 12'h000;
      TEST_OVERFLOW <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      RDATA <= nxt_rdata;
      RVALID <= nxt_rvalid;
      // Counts above the cap are clamped so the window never passes 38.5 us.
      if (hit(ADDR, `OFS_CLEAR_WINDOW)) begin
        window_ff <= (WDATA[9:0] > `CLEAR_WINDOW_MAX) ? `CLEAR_WINDOW_MAX : WDATA[9:0];
      end
      CLEAR_WINDOW_CYCLES <= window_cycles(window_ff);
      MEM_TEST_MODE <= mode_ff[`BIT_MEM_TEST];
      CONV_OFFLINE <= mode_ff[`BIT_CONV_HALT];
      DATA_RESET <= mode_ff[`BIT_DATA_WIPE];
      STORE_OVERFLOWED <= mode_ff[`BIT_OVF_CHECK_DIS];
      STORE_ALL_LEVELS <= mode_ff[`BIT_ZERO_SUP_DIS];
      ACQ_CHECK_MODE <= mode_ff[`BIT_ACQ_CHECK];
      SLIDE_DAC_FIXED <= ~mode_ff[`BIT_DITHER_SCALE];
      SLIDE_SUB_BYPASS <= mode_ff[`BIT_SLIDE_SUB_DIS];
      PTR_AUTO_ADVANCE <= mode_ff[`BIT_PTR_AUTO_ADV];
      EMPTY_EVENT_RECORD <= mode_ff[`BIT_EMPTY_EVENT];
      COUNT_EVERY_TRIGGER <= mode_ff[`BIT_COUNT_EVERY];
      if (mode_ff[`BIT_THRESHOLD_STEP]) begin
        ABOVE_THRESHOLD <= CONV_RESULT[8:1] > THRESHOLD;
      end else begin
        ABOVE_THRESHOLD <= CONV_RESULT[11:4] > THRESHOLD;
      end
      if (hit(ADDR, `OFS_SLIDE_CONST)) begin
        SLIDE_DAC_CONST <= WDATA[7:0];
      end
      // Manual advance strobes only act while auto-advance is off.
      ADVANCE_EVENT <= hit(ADDR, `OFS_INCR_EVENT) & ~mode_ff[`BIT_PTR_AUTO_ADV];
      ADVANCE_WORD <= hit(ADDR, `OFS_INCR_OFFSET) & ~mode_ff[`BIT_PTR_AUTO_ADV];
      EVENT_COUNT_CLEAR <= hit(ADDR, `OFS_EVENT_COUNT_CLEAR);
      if (hit(ADDR, `OFS_TEST_WR_ADDR)) begin
        MEM_TEST_WR_ADDR <= WDATA;
      end
      if (hit(ADDR, `OFS_TEST_RD_ADDR)) begin
        MEM_TEST_RD_ADDR <= WDATA;
      end
      if (hit(ADDR, `OFS_TEST_PAT_UPPER)) begin
        upper_ff <= WDATA;
      end
      // Commit needs test mode; upper half is whatever was last written.
      MEM_TEST_COMMIT <= hit(ADDR, `OFS_TEST_PAT_LOWER) & mode_ff[`BIT_MEM_TEST];
      if (hit(ADDR, `OFS_TEST_PAT_LOWER)) begin
        MEM_TEST_WORD <= {upper_ff, WDATA};
      end
      if (hit(ADDR, `OFS_CRATE_NUMBER)) begin
        CRATE_NUMBER <= WDATA[7:0];
      end
      if (hit(ADDR, `OFS_PEDESTAL)) begin
        PEDESTAL_CURRENT <= WDATA[7:0];
      end
      // Pointers wrap, so a 33rd write overwrites the oldest slot.
      if (hit(ADDR, `OFS_TEST_EVENT_LOAD)) begin
        wptr_ff <= wptr_ff + 5'h01;
      end
      if (TEST_FIFO_POP) begin
        rptr_ff <= rptr_ff + 5'h01;
      end
      TEST_VALUE <= fifo_mem[rptr_ff][11:0];
      TEST_OVERFLOW <= fifo_mem[rptr_ff][12];
    end
  end

  // Storage has no reset; unloaded entries are undefined, as with the real part.
  always @(posedge CLK) begin
    if (hit(ADDR, `OFS_TEST_EVENT_LOAD)) begin
      fifo_mem[wptr_ff] <= WDATA;
    end
  end
endmodule

/* dv/mode_regs_assertions.sv */
// Port checks for the mode and test register bank.
`timescale 1ns/10ps
module mode_regs_assertions (
  input wire CLK,
  input wire RST,
  input wire WR,
  input wire RD,
  input wire [15:0] ADDR,
  input wire [15:0] WDATA,
  input wire RVALID,
  input wire DATA_RESET,
  input wire EVENT_COUNT_CLEAR,
  input wire [15:0] CLEAR_WINDOW_CYCLES,
  input wire MEM_TEST_MODE,
  input wire MEM_TEST_COMMIT,
  input wire [31:0] MEM_TEST_WORD,
  input wire PTR_AUTO_ADVANCE,
  input wire ADVANCE_EVENT,
  input wire [7:0] CRATE_NUMBER
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Counts above the ceiling are clamped, so the expected width is taken from the clamped count.
  wire [9:0] n = (WDATA[9:0] > 10'h3f0) ? 10'h3f0 : WDATA[9:0];
  wire [15:0] win = 16'((32'd7000 + (32'(n) * 1000) / 32 + 9) / 10);
  sequence s_wr(logic [15:0] a);
    WR && ADDR == a;
  endsequence
  property p_read; RD |=> RVALID; endproperty
  a_read: assert property (p_read) else $error("read answer missing");
  property p_set; s_wr(16'h1032) ##0 WDATA[2] |-> ##2 DATA_RESET; endproperty
  a_set: assert property (p_set) else $error("mode bit not set");
  property p_clear; s_wr(16'h1034) ##0 WDATA[2] |-> ##2 !DATA_RESET; endproperty
  a_clear: assert property (p_clear) else $error("mode bit not cleared");
  property p_window; s_wr(16'h102e) |=> ##1 CLEAR_WINDOW_CYCLES == $past(win, 2); endproperty
  a_window: assert property (p_window) else $error("window width wrong");
  property p_count; s_wr(16'h1040) |=> EVENT_COUNT_CLEAR; endproperty
  a_count: assert property (p_count) else $error("counter clear missing");
  property p_commit;
    s_wr(16'h103a) ##0 MEM_TEST_MODE |=> MEM_TEST_COMMIT && MEM_TEST_WORD[15:0] == $past(WDATA);
  endproperty
  a_commit: assert property (p_commit) else $error("test word not committed");
  property p_adv; s_wr(16'h1028) ##0 !PTR_AUTO_ADVANCE |=> ADVANCE_EVENT; endproperty
  a_adv: assert property (p_adv) else $error("event advance missing");
  property p_crate; s_wr(16'h103c) |=> CRATE_NUMBER == $past(WDATA[7:0]); endproperty
  a_crate: assert property (p_crate) else $error("crate number wrong");
endmodule
bind mode_regs mode_regs_assertions chk (.*);

/* dv/host_model.sv */
// Bus master model issuing single register writes and reads.
`timescale 1ns/10ps
module host_model (
  input wire CLK,
  input wire RVALID,
  input wire [15:0] RDATA,
  output logic WR,
  output logic RD,
  output logic [15:0] ADDR,
  output logic [15:0] WDATA
);
  initial {WR, RD, ADDR, WDATA} = 34'h0;
  // Address is inverted after each access, and data after a write, so a stale value never passes for a request.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge CLK);
    {WR, ADDR, WDATA} = {1'b1, a, d};
    @(negedge CLK);
    {WR, ADDR, WDATA} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge CLK);
    {RD, ADDR} = {1'b1, a};
    @(negedge CLK);
    d = (RVALID === 1'b1) ? RDATA : 16'hxxxx;
    {RD, ADDR} = {1'b0, ~a};
  endtask
endmodule

/* dv/mode_regs_test.sv */
// Self-checking bench for the mode and test register bank.
`timescale 1ns/10ps
module mode_regs_test;
  logic clk, rst, wr, rd, pop, rvalid, tov, above, auto;
  logic [15:0] addr, wdata, rdata, win, d, twa, tra;
  logic [31:0] mword;
  logic [11:0] tval;
  int fails = 0;
  int comparisons = 0;
  logic [63:0] rows [8] = '{
    {16'h1032, 16'h0001, 16'h1032, 16'h4881}, {16'h1034, 16'h4000, 16'h1032, 16'h0881},
    {16'h1032, 16'hffff, 16'h1032, 16'h79df}, {16'h1034, 16'h0004, 16'h1032, 16'h79db},
    {16'h102e, 16'h03ff, 16'h102e, 16'h03f0}, {16'h103c, 16'h0012, 16'h103c, 16'h0012},
    {16'h1036, 16'h1234, 16'h1036, 16'h0000}, {16'h1100, 16'hffff, 16'h1100, 16'h0000}};
  host_model host (.CLK(clk), .RVALID(rvalid), .RDATA(rdata), .WR(wr), .RD(rd),
    .ADDR(addr), .WDATA(wdata));
  mode_regs DUT (.CLK(clk), .RST(rst), .WR(wr), .RD(rd), .ADDR(addr), .WDATA(wdata),
    .RDATA(rdata), .RVALID(rvalid), .TEST_FIFO_POP(pop), .CONV_RESULT(12'h020),
    .THRESHOLD(8'h0f), .CLEAR_WINDOW_CYCLES(win), .MEM_TEST_MODE(), .CONV_OFFLINE(),
    .DATA_RESET(), .STORE_OVERFLOWED(), .STORE_ALL_LEVELS(), .ACQ_CHECK_MODE(),
    .SLIDE_DAC_CONST(), .SLIDE_DAC_FIXED(), .SLIDE_SUB_BYPASS(), .ABOVE_THRESHOLD(above),
    .PTR_AUTO_ADVANCE(auto), .ADVANCE_EVENT(), .ADVANCE_WORD(), .EMPTY_EVENT_RECORD(),
    .COUNT_EVERY_TRIGGER(), .EVENT_COUNT_CLEAR(), .MEM_TEST_WR_ADDR(twa),
    .MEM_TEST_RD_ADDR(tra), .MEM_TEST_WORD(mword), .MEM_TEST_COMMIT(), .CRATE_NUMBER(),
    .PEDESTAL_CURRENT(), .TEST_VALUE(tval), .TEST_OVERFLOW(tov));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #50000;
    fails++;
    conclude;
  end
  initial begin
    {rst, pop} = 2'b10;
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    host.rd(16'h1032, d);
    check(d, 16'h4880);
    check(win, 16'd700);
    check({above, auto}, 2'b01);
    for (int i = 0; i < 8; i++) begin
      host.wr(rows[i][63:48], rows[i][47:32]);
      host.rd(rows[i][31:16], d);
      check(d, rows[i][15:0]);
    end
    check({above, win}, {1'b1, 16'd3850});
    host.wr(16'h1036, 16'h0010);
    host.wr(16'h1064, 16'h0020);
    check({twa, tra}, 32'h00100020);
    host.wr(16'h1038, 16'habcd);
    host.wr(16'h103a, 16'h1234);
    check(mword, 32'habcd1234);
    host.wr(16'h1034, 16'h0800);
    host.wr(16'h1028, 16'h0000);
    host.wr(16'h1040, 16'hffff);
    for (int i = 0; i < 32; i++) host.wr(16'h103e, {3'h0, i[0], 12'(i * 5 + 1)});
    @(negedge clk);
    check({tov, tval}, 13'h0001);
    pop = 1'b1;
    @(negedge clk) pop = 1'b0;
    @(negedge clk);
    check({tov, tval}, {1'b1, 12'd6});
    rst = 1'b1;
    @(negedge clk) rst = 1'b0;
    host.rd(16'h1032, d);
    check(d, 16'h4880);
    conclude;
  end
endmodule
